// >>> rtl/led_matrix_defs.vh
`ifndef LED_MATRIX_DEFS_VH
`define LED_MATRIX_DEFS_VH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_PWM_FIRST   8'h01
`define ADDR_PWM_LAST    8'h48
`define ADDR_CONFIG      8'h50
`define ADDR_GCS         8'h51
`define ADDR_FREQ_EN     8'hE0
`define ADDR_FREQ_SEL    8'hE2
`define ADDR_STATUS      8'hE4

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define CFG_SRS_HI       7
`define CFG_SRS_LO       4
`define CFG_RUN_BIT      0
`define FREQ_SEL_HI      7
`define FREQ_SEL_LO      5
`define FREQ_EN_BIT      0
`define CONFIG_RST       8'h00
`define GCS_RST          8'h00
`define FREQ_SEL_RST     3'h0
`define DUTY_RST         8'h00

// ------------------------------------------------------------
// scan row select encodings
// ------------------------------------------------------------
`define SRS_FOUR         4'h0
`define SRS_THREE        4'h1
`define SRS_TWO          4'h2
`define SRS_STATIC       4'h3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_HZ           50000000
`define SCAN_PERIOD_NS   33000
`define ROW_BLANK_NS     830
`define SINK_DELAY_NS    300
`define PWM_BASE_HZ      29000
`define PWM_STEPS        256
`define SCAN_CYC         ((`SCAN_PERIOD_NS * (`CLK_HZ / 1000000)) / 1000)
`define ROW_BLANK_CYC    ((`ROW_BLANK_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define SINK_DELAY_CYC   ((`SINK_DELAY_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define PWM_STEP_CYC     (`CLK_HZ / (`PWM_BASE_HZ * `PWM_STEPS))

`endif

// >>> rtl/pwm_step_divider.v
`timescale 1ns/1ns
`include "led_matrix_defs.vh"

module pwm_step_divider #(
	parameter BASE_CYC = `PWM_STEP_CYC,
	parameter CNT_W    = 12
) (
	// clock and reset
	input  wire             clk_in,
	input  wire             reset_n_in,
	// control
	input  wire [2:0]       freq_sel_in,
	// step enable
	output reg              step_out
);

	reg  [CNT_W-1:0] cnt_r;
	reg  [2:0]       shift;
	wire [CNT_W-1:0] limit;

	// ------------------------------------------------------------
	// 000 and 111 both give the base rate, each step up from 000 to 110 halves it
	// ------------------------------------------------------------
	always @* begin
		shift = freq_sel_in;
		if (freq_sel_in == 3'h7) begin
			shift = 3'h0;
		end
	end

	assign limit = (BASE_CYC[CNT_W-1:0] << shift) - {{(CNT_W-1){1'b0}}, 1'b1};

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_r    <= {CNT_W{1'b0}};
			step_out <= 1'b0;
		end else if (cnt_r >= limit) begin
			cnt_r    <= {CNT_W{1'b0}};
			step_out <= 1'b1;
		end else begin
			cnt_r    <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			step_out <= 1'b0;
		end
	end

endmodule

// >>> rtl/led_matrix_scan_pwm.v
`timescale 1ns/1ns
`include "led_matrix_defs.vh"

module led_matrix_scan_pwm #(
	parameter ROWS = 4,
	parameter COLS = 18
) (
	// clock and reset
	input  wire              clk_in,
	input  wire              reset_n_in,
	// register port
	input  wire              reg_wr_en_in,
	input  wire              reg_rd_en_in,
	input  wire [7:0]        reg_addr_in,
	input  wire [7:0]        reg_wdata_in,
	output reg  [7:0]        reg_rdata_out,
	// matrix drive
	output reg  [ROWS-1:0]   row_switch_output_out,
	output reg  [COLS-1:0]   column_current_sink_out,
	output wire [7:0]        global_current_scale_out
);

	localparam LEDS     = ROWS * COLS;
	localparam ST_BLANK = 1'b0;
	localparam ST_ON    = 1'b1;
	// on time per row slot, blanking taken out of each slot
	localparam integer ON_FOUR_I  = `SCAN_CYC / 4 - `ROW_BLANK_CYC;
	localparam integer ON_THREE_I = `SCAN_CYC / 3 - `ROW_BLANK_CYC;
	localparam integer ON_TWO_I   = `SCAN_CYC / 2 - `ROW_BLANK_CYC;
	localparam integer COLS_I     = COLS;

	reg  [7:0]  duty_r    [0:LEDS-1];
	reg  [7:0]  shadow_r  [0:LEDS-1];
	reg  [7:0]  config_r;
	reg  [7:0]  gcs_r;
	reg         freq_change_enable_r;
	reg  [2:0]  pwm_freq_field_r;
	reg  [7:0]  pwm_cnt_r;
	reg         state_r;
	reg  [1:0]  row_r;
	reg  [11:0] slot_cnt_r;
	reg  [11:0] on_len;
	reg  [1:0]  last_row;
	reg         sink_en;
	wire        step;
	wire        pwm_wrap;
	wire        run;
	wire [3:0]  scan_row_select;
	wire        is_static;
	wire [6:0]  row_base;
	wire        duty_hit;
	wire [6:0]  duty_idx;
	integer     i;

	assign global_current_scale_out = gcs_r;
	assign run             = config_r[`CFG_RUN_BIT];
	assign scan_row_select = config_r[`CFG_SRS_HI:`CFG_SRS_LO];
	assign is_static       = (scan_row_select == `SRS_STATIC);
	assign duty_hit        = reg_addr_in >= `ADDR_PWM_FIRST && reg_addr_in <= `ADDR_PWM_LAST;
	assign duty_idx        = reg_addr_in[6:0] - 7'h01;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			config_r             <= `CONFIG_RST;
			gcs_r                <= `GCS_RST;
			freq_change_enable_r <= 1'b0;
			pwm_freq_field_r     <= `FREQ_SEL_RST;
			for (i = 0; i < LEDS; i = i + 1) begin
				duty_r[i] <= `DUTY_RST;
			end
		end else if (reg_wr_en_in) begin
			if (duty_hit) begin
				duty_r[duty_idx] <= reg_wdata_in;
			end
			case (reg_addr_in)
				`ADDR_CONFIG: config_r <= reg_wdata_in;
				`ADDR_GCS:    gcs_r <= reg_wdata_in;
				`ADDR_FREQ_EN: freq_change_enable_r <= reg_wdata_in[`FREQ_EN_BIT];
				`ADDR_FREQ_SEL: begin
					if (freq_change_enable_r) begin
						pwm_freq_field_r <= reg_wdata_in[`FREQ_SEL_HI:`FREQ_SEL_LO];
					end
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// register reads, one cycle latency
	// ------------------------------------------------------------
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_en_in) begin
			if (duty_hit) begin
				reg_rdata_out <= duty_r[duty_idx];
			end else begin
				case (reg_addr_in)
					`ADDR_CONFIG: reg_rdata_out <= config_r;
					`ADDR_GCS:    reg_rdata_out <= gcs_r;
					`ADDR_FREQ_EN:  reg_rdata_out <= {7'h00, freq_change_enable_r};
					`ADDR_FREQ_SEL: reg_rdata_out <= {pwm_freq_field_r, 5'h00};
					`ADDR_STATUS: reg_rdata_out <= {4'h0, |row_switch_output_out, state_r, row_r};
					default:      reg_rdata_out <= 8'h00;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// pwm step rate and 256-step counter
	// ------------------------------------------------------------
	pwm_step_divider #(
		.BASE_CYC (`PWM_STEP_CYC),
		.CNT_W    (12)
	) u_div (
		.clk_in      (clk_in),
		.reset_n_in  (reset_n_in),
		.freq_sel_in (pwm_freq_field_r),
		.step_out    (step)
	);

	assign pwm_wrap = step && (pwm_cnt_r == 8'hFF);

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pwm_cnt_r <= 8'h00;
			for (i = 0; i < LEDS; i = i + 1) begin
				shadow_r[i] <= `DUTY_RST;
			end
		end else begin
			if (step) begin
				pwm_cnt_r <= pwm_cnt_r + 8'h01;
			end
			if (pwm_wrap) begin
				for (i = 0; i < LEDS; i = i + 1) begin
					shadow_r[i] <= duty_r[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// row slot length by scan row select
	// ------------------------------------------------------------
	always @* begin
		case (scan_row_select)
			`SRS_THREE: begin
				on_len   = ON_THREE_I[11:0];
				last_row = 2'd2;
			end
			`SRS_TWO: begin
				on_len   = ON_TWO_I[11:0];
				last_row = 2'd1;
			end
			default: begin
				on_len   = ON_FOUR_I[11:0];
				last_row = 2'd3;
			end
		endcase
	end

	// ------------------------------------------------------------
	// row scanner
	// ------------------------------------------------------------
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r               <= ST_BLANK;
			row_r                 <= 2'd0;
			slot_cnt_r            <= 12'h000;
			row_switch_output_out <= {ROWS{1'b0}};
		end else if (!run || is_static) begin
			state_r               <= ST_BLANK;
			row_r                 <= 2'd0;
			slot_cnt_r            <= 12'h000;
			row_switch_output_out <= {ROWS{1'b0}};
		end else begin
			case (state_r)
				ST_BLANK: begin
					if (slot_cnt_r >= `ROW_BLANK_CYC - 1) begin
						state_r    <= ST_ON;
						slot_cnt_r <= 12'h000;
						row_switch_output_out <= {{(ROWS-1){1'b0}}, 1'b1} << row_r;
					end else begin
						slot_cnt_r <= slot_cnt_r + 12'h001;
					end
				end
				ST_ON: begin
					if (slot_cnt_r >= on_len - 12'h001) begin
						state_r    <= ST_BLANK;
						slot_cnt_r <= 12'h000;
						row_switch_output_out <= {ROWS{1'b0}};
						row_r      <= (row_r >= last_row) ? 2'd0 : row_r + 2'd1;
					end else begin
						slot_cnt_r <= slot_cnt_r + 12'h001;
					end
				end
				default: begin
					state_r <= ST_BLANK;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// column sinks compare against the lit row's duties, or row 0's in static mode where no row is lit
	// ------------------------------------------------------------
	always @* begin
		sink_en = 1'b0;
		if (run && is_static) begin
			sink_en = 1'b1;
		end else if (run && state_r == ST_ON && slot_cnt_r >= `SINK_DELAY_CYC - 1
				&& slot_cnt_r < on_len - 12'h001) begin
			sink_en = 1'b1;
		end
	end

	assign row_base = {5'h00, row_r} * COLS_I[6:0];

	genvar c;
	generate
		for (c = 0; c < COLS; c = c + 1) begin : g_col
			always @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					column_current_sink_out[c] <= 1'b0;
				end else begin
					column_current_sink_out[c] <= sink_en
						&& (pwm_cnt_r < shadow_r[row_base + c]);
				end
			end
		end
	endgenerate

endmodule

// >>> verification/led_matrix_scan_pwm_checker.sv
`timescale 1ns/1ns
module led_matrix_scan_pwm_checker #(
	parameter ROWS = 4,
	parameter COLS = 18
) (
	input wire            clk_in,
	input wire            reset_n_in,
	input wire            reg_wr_en_in,
	input wire            reg_rd_en_in,
	input wire [7:0]      reg_addr_in,
	input wire [7:0]      reg_wdata_in,
	input wire [7:0]      reg_rdata_out,
	input wire [ROWS-1:0] row_switch_output_out,
	input wire [COLS-1:0] column_current_sink_out,
	input wire [7:0]      global_current_scale_out
);
	wire       row_on;
	reg [11:0] on_cnt_r;
	reg [11:0] off_cnt_r;
	assign row_on = |row_switch_output_out;
	// run lengths of row on and off phases
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			on_cnt_r  <= 12'h000;
			off_cnt_r <= 12'h000;
		end else begin
			on_cnt_r  <= row_on ? on_cnt_r + 12'h001 : 12'h000;
			off_cnt_r <= row_on ? 12'h000 : off_cnt_r + {11'h000, off_cnt_r != 12'hFFF};
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_row_release;
		$fell(row_on);
	endsequence
	sequence s_quiet8;
		(!row_on && column_current_sink_out == '0) [*8];
	endsequence
	a_row_onehot: assert property ($onehot0(row_switch_output_out))
		else $error("more than one row switch on");
	a_row_order: assert property ($rose(row_switch_output_out[1]) |-> $past(row_switch_output_out, 43) == 1)
		else $error("row 1 not preceded by row 0");
	a_row_length: assert property (s_row_release |-> on_cnt_r == 370 || on_cnt_r == 508 || on_cnt_r == 783)
		else $error("row on time wrong");
	a_blank_gap: assert property ($rose(row_on) |-> off_cnt_r >= 42)
		else $error("blanking too short");
	a_blank_quiet: assert property (s_row_release |-> s_quiet8)
		else $error("activity during blanking");
	a_sink_delay: assert property (row_on && on_cnt_r < 15 |-> column_current_sink_out == '0)
		else $error("sink before delay");
	a_unmapped_zero: assert property (reg_rd_en_in && reg_addr_in == 8'h49 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_scale_copy: assert property (reg_wr_en_in && reg_addr_in == 8'h51 |=> global_current_scale_out == $past(reg_wdata_in))
		else $error("scale output not updated");
endmodule

bind led_matrix_scan_pwm led_matrix_scan_pwm_checker #(.ROWS(ROWS), .COLS(COLS)) u_led_matrix_scan_pwm_checker (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.row_switch_output_out(row_switch_output_out), .column_current_sink_out(column_current_sink_out),
	.global_current_scale_out(global_current_scale_out));

// >>> verification/host_ctrl_model.sv
`timescale 1ns/1ns
module host_ctrl_model (
	// clock
	input  wire       clk_in,
	// register port
	output reg        wr_en_out,
	output reg        rd_en_out,
	output reg  [7:0] addr_out,
	output reg  [7:0] wdata_out,
	input  wire [7:0] rdata_in
);
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out  = 8'h00;
		wdata_out = 8'h00;
	end
	// one strobe per call; released lines show the inverse value
	task xfer(input is_rd, input [7:0] a, input [7:0] d, output [7:0] q);
	begin
		@(negedge clk_in);
		addr_out  = a;
		wdata_out = d;
		wr_en_out = !is_rd;
		rd_en_out = is_rd;
		@(negedge clk_in);
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out  = ~a;
		wdata_out = ~d;
		@(negedge clk_in);
		q = rdata_in;
	end
	endtask
endmodule

// >>> verification/led_matrix_scan_pwm_tb.sv
`timescale 1ns/1ns
module led_matrix_scan_pwm_tb;
	reg         clk_in;
	reg         reset_n_in;
	wire        wr_en;
	wire        rd_en;
	wire [7:0]  addr;
	wire [7:0]  wdata;
	wire [7:0]  rdata;
	wire [7:0]  gcs;
	wire [3:0]  rows;
	wire [17:0] cols;
	reg  [7:0]  rv;
	reg  [47:0] tab = 48'h5051E0E20148;
	integer     n_errors;
	integer     check_count;
	integer     i;
	integer     hi;
	integer     lo;

	led_matrix_scan_pwm u_led_matrix_scan_pwm (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .row_switch_output_out(rows), .column_current_sink_out(cols),
		.global_current_scale_out(gcs));
	host_ctrl_model u_host_ctrl_model (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
		.addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task check(input [31:0] seen, input [31:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	end
	endtask
	task finish_test;
	begin
		if (n_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	end
	endtask
	task do_reset;
	begin
		reset_n_in = 1'b0;
		repeat (4) @(negedge clk_in);
		reset_n_in = 1'b1;
	end
	endtask
	task count_while(input [3:0] pat, input eq, output integer n, output integer s);
	begin
		n = 0;
		s = 0;
		while (((rows === pat) == eq) && n < 3000) begin
			s = s + cols[0];
			n = n + 1;
			@(negedge clk_in);
		end
	end
	endtask
	task scan_mode(input [3:0] sel, input integer len);
	begin
		do_reset;
		u_host_ctrl_model.xfer(1'b0, 8'h13, 8'hFF, rv);
		// let one pwm wrap copy the new duty into use
		repeat (1600) @(negedge clk_in);
		u_host_ctrl_model.xfer(1'b0, 8'h50, {sel, 4'h1}, rv);
		count_while(4'h1, 1'b0, hi, lo);
		count_while(4'h1, 1'b1, hi, lo);
		check(hi, len);
		check(lo, 0);
		count_while(4'h0, 1'b1, hi, lo);
		check(hi, 42);
		check(rows, 4'h2);
		u_host_ctrl_model.xfer(1'b1, 8'hE4, 8'h00, rv);
		check(rv, 8'h0D);
		count_while(4'h2, 1'b1, hi, lo);
		check(lo > 200, 1);
		count_while(4'h1, 1'b0, hi, lo);
		check(hi, 42 + (2 - sel) * (len + 42));
	end
	endtask
	task pwm_meas(input [2:0] fsel, input [7:0] d);
	integer step;
	begin
		step = 6 << ((fsel == 3'h7) ? 0 : fsel);
		u_host_ctrl_model.xfer(1'b0, 8'h01, d, rv);
		u_host_ctrl_model.xfer(1'b0, 8'hE2, {fsel, 5'h00}, rv);
		u_host_ctrl_model.xfer(1'b1, 8'hE2, 8'h00, rv);
		check(rv, {fsel, 5'h00});
		for (i = 0; i < 9000 && cols[0] !== 1'b0; i = i + 1) @(negedge clk_in);
		for (i = 0; i < 9000 && cols[0] !== 1'b1; i = i + 1) @(negedge clk_in);
		hi = 0;
		lo = 0;
		for (i = 0; i < 512 * step; i = i + 1) begin
			hi = hi + cols[0];
			lo = lo + cols[1] + rows;
			@(negedge clk_in);
		end
		check(hi, 2 * d * step);
		check(lo, 0);
	end
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		n_errors = 0;
		check_count = 0;
		do_reset;
		for (i = 0; i < 6; i = i + 1) begin
			u_host_ctrl_model.xfer(1'b1, tab[8*i +: 8], 8'h00, rv);
			check(rv, 8'h00);
		end
		u_host_ctrl_model.xfer(1'b0, 8'h49, 8'hAA, rv);
		u_host_ctrl_model.xfer(1'b1, 8'h49, 8'h00, rv);
		check(rv, 8'h00);
		u_host_ctrl_model.xfer(1'b0, 8'h48, 8'hC3, rv);
		u_host_ctrl_model.xfer(1'b1, 8'h48, 8'h00, rv);
		check(rv, 8'hC3);
		u_host_ctrl_model.xfer(1'b0, 8'h51, 8'h5A, rv);
		check(gcs, 8'h5A);
		u_host_ctrl_model.xfer(1'b0, 8'hE2, 8'hA0, rv);
		u_host_ctrl_model.xfer(1'b1, 8'hE2, 8'h00, rv);
		check(rv, 8'h00);
		u_host_ctrl_model.xfer(1'b0, 8'hE0, 8'hFF, rv);
		u_host_ctrl_model.xfer(1'b1, 8'hE0, 8'h00, rv);
		check(rv, 8'h01);
		scan_mode(4'h0, 370);
		scan_mode(4'h1, 508);
		scan_mode(4'h2, 783);
		do_reset;
		u_host_ctrl_model.xfer(1'b0, 8'h50, 8'h31, rv);
		u_host_ctrl_model.xfer(1'b0, 8'hE0, 8'h01, rv);
		// gamma table points
		pwm_meas(3'h0, 8'd78);
		pwm_meas(3'h1, 8'd149);
		pwm_meas(3'h7, 8'd78);
		pwm_meas(3'h0, 8'd255);
		finish_test;
	end
	// about twice the expected run length
	initial begin
		#1500000;
		n_errors = n_errors + 1;
		finish_test;
	end
endmodule
